/* File: common/sas_pkg.sv */
`default_nettype none
package sas_pkg;
   // core clock rate
   localparam int CORE_MHZ = 125;

   // result word
   localparam int RES_BITS = 10;
   localparam logic [9:0] RES_ONES = 10'h3ff;
   localparam logic [9:0] RES_ZEROS = 10'h000;
   localparam logic [9:0] RES_RST = 10'h000;

   // sampling window in shift-clock falling edges
   localparam logic [3:0] SAMPLE_FIRST = 4'h3;
   localparam logic [3:0] SAMPLE_LAST = 4'ha;

   // select filter: least time, rounds up
   localparam int CS_FILT_NS = 1425;
   localparam int CS_FILT_CYC = (CS_FILT_NS * CORE_MHZ + 999) / 1000;
   localparam logic [7:0] FILT_LAST = 8'(CS_FILT_CYC - 1);

   // conversion time: longest time, rounds down
   localparam int CONV_NS = 21000;
   localparam int CONV_CYC = CONV_NS * CORE_MHZ / 1000;
   localparam int STEP_CYC = CONV_CYC / RES_BITS;
   localparam logic [8:0] STEP_LAST = 9'(STEP_CYC - 1);
   localparam logic [11:0] CONV_MAX = 12'(CONV_CYC);

   // abort window after the tenth falling edge: longest time, rounds down
   localparam int ABORT_NS = 9000;
   localparam int ABORT_CYC = ABORT_NS * CORE_MHZ / 1000;
   localparam logic [10:0] ABORT_LIM = 11'(ABORT_CYC);

   // output enable and disable limits
   localparam int EN_NS = 1300;
   localparam int EN_CYC = EN_NS * CORE_MHZ / 1000;
   localparam int DIS_NS = 180;
   localparam int DIS_CYC = DIS_NS * CORE_MHZ / 1000;

   // result queue
   localparam int FIFO_DEPTH = 16;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_XFER = 4'b0010,
      ST_CONV = 4'b0100,
      ST_DONE = 4'b1000
   } sas_state_t;
endpackage
`default_nettype wire

/* File: hdl/sas_fifo.sv */
`default_nettype none
module sas_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    wr_d;
   logic [AW-1:0]    rd_q;
   logic [AW-1:0]    rd_d;
   logic [AW:0]      cnt_q;
   logic [AW:0]      cnt_d;
   logic             in_fire;
   logic             out_fire;

   assign in_ready  = (cnt_q != (AW + 1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];

   // pointers wrap naturally: depth is a power of two
   always_comb begin
      in_fire  = in_valid & in_ready;
      out_fire = out_valid & out_ready;
      wr_d     = in_fire ? wr_q + 1'b1 : wr_q;
      rd_d     = out_fire ? rd_q + 1'b1 : rd_q;
      cnt_d    = cnt_q;
      if (in_fire && !out_fire) begin
         cnt_d = cnt_q + 1'b1;
      end else if (!in_fire && out_fire) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
      if (in_fire) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/sas_seq.sv */
// Operation
// - input above upper reference yields the all-ones result code
// - input below lower reference yields the all-zeros result code
// - after select falls, shift clock ignored until select filter time passes
// - sampling runs from third to tenth falling shift-clock edge
// - access, sampling and conversion end within 21 us plus ten clock periods
// - select falling within 9 us after tenth fall aborts the conversion
// - a select change counts only once held for 1.425 us
// - output drives MSB within 1.3 us of select low, floats within 180 ns
// - select rising disables the shift clock within the filter time
`default_nettype none
module sas_seq (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       cs_n,
   input  wire logic       io_clk,
   input  wire logic       cmp_above,
   input  wire logic       ain_over_ref_hi,
   input  wire logic       ain_under_ref_lo,
   output logic            data_out,
   output logic            data_oe_n,
   output logic            sample_en,
   output logic      [9:0] dac_code,
   output logic            conv_busy
);
   function automatic logic [9:0] bit_mask(input logic [3:0] idx);
      bit_mask = 10'h001 << idx;
   endfunction

   // pin synchronisers and select filter
   logic [2:0] cs_sync_q;
   logic [2:0] cs_sync_d;
   logic [2:0] io_sync_q;
   logic [2:0] io_sync_d;
   logic       cs_lvl_q;
   logic       cs_lvl_d;
   logic       io_lvl_q;
   logic       io_lvl_d;
   logic       cs_valid_q;
   logic       cs_valid_d;
   logic [7:0] filt_cnt_q;
   logic [7:0] filt_cnt_d;
   logic       io_fall;
   logic       cs_vfall;

   always_comb begin
      cs_sync_d  = {cs_sync_q[1:0], cs_n};
      io_sync_d  = {io_sync_q[1:0], io_clk};
      cs_lvl_d   = (cs_sync_q[1] == cs_sync_q[2]) ? cs_sync_q[2] : cs_lvl_q;
      io_lvl_d   = (io_sync_q[1] == io_sync_q[2]) ? io_sync_q[2] : io_lvl_q;
      io_fall    = io_lvl_q & ~io_sync_q[1] & ~io_sync_q[2];
      cs_valid_d = cs_valid_q;
      filt_cnt_d = 8'h00;
      cs_vfall   = 1'b0;
      // new level must hold for the whole filter time, else restart
      if (cs_lvl_q != cs_valid_q) begin
         if (filt_cnt_q == sas_pkg::FILT_LAST) begin
            cs_valid_d = cs_lvl_q;
            cs_vfall   = ~cs_lvl_q;
         end else begin
            filt_cnt_d = filt_cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         cs_sync_q  <= 3'h7;
         io_sync_q  <= 3'h0;
         cs_lvl_q   <= 1'b1;
         io_lvl_q   <= 1'b0;
         cs_valid_q <= 1'b1;
         filt_cnt_q <= 8'h00;
      end else begin
         cs_sync_q  <= cs_sync_d;
         io_sync_q  <= io_sync_d;
         cs_lvl_q   <= cs_lvl_d;
         io_lvl_q   <= io_lvl_d;
         cs_valid_q <= cs_valid_d;
         filt_cnt_q <= filt_cnt_d;
      end
   end

   // transfer and conversion sequencer
   sas_pkg::sas_state_t state_q;
   sas_pkg::sas_state_t state_d;
   logic [3:0]  edge_cnt_q;
   logic [3:0]  edge_cnt_d;
   logic [9:0]  shift_q;
   logic [9:0]  shift_d;
   logic        sample_q;
   logic        sample_d;
   logic [9:0]  trial_q;
   logic [9:0]  trial_d;
   logic [3:0]  bit_q;
   logic [3:0]  bit_d;
   logic [8:0]  step_q;
   logic [8:0]  step_d;
   logic [10:0] win_q;
   logic [10:0] win_d;
   logic [9:0]  res_q;
   logic [9:0]  res_d;
   logic [11:0] age_q;
   logic [11:0] age_d;
   logic [9:0]  kept;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   logic [9:0]  fifo_out_data;

   always_comb begin
      state_d        = state_q;
      edge_cnt_d     = edge_cnt_q;
      shift_d        = shift_q;
      sample_d       = sample_q;
      trial_d        = trial_q;
      bit_d          = bit_q;
      step_d         = step_q;
      win_d          = win_q;
      res_d          = res_q;
      age_d          = age_q;
      fifo_out_ready = 1'b0;
      kept           = cmp_above ? trial_q : (trial_q & ~bit_mask(bit_q));
      case (state_q)
         sas_pkg::ST_IDLE: begin
            if (!cs_lvl_q) begin
               fifo_out_ready = 1'b1;
               // MSB of the previous result is ready before any clock
               shift_d    = fifo_out_valid ? fifo_out_data : sas_pkg::RES_RST;
               edge_cnt_d = 4'h0;
               state_d    = sas_pkg::ST_XFER;
            end
         end
         sas_pkg::ST_XFER: begin
            if (cs_lvl_q && cs_valid_q) begin
               state_d  = sas_pkg::ST_IDLE;
               sample_d = 1'b0;
            end else if (io_fall && !cs_valid_q) begin
               edge_cnt_d = edge_cnt_q + 4'h1;
               shift_d    = {shift_q[8:0], 1'b0};
               if (edge_cnt_q == sas_pkg::SAMPLE_FIRST - 4'h1) begin
                  sample_d = 1'b1;
               end
               if (edge_cnt_q == sas_pkg::SAMPLE_LAST - 4'h1) begin
                  sample_d = 1'b0;
                  state_d  = sas_pkg::ST_CONV;
                  trial_d  = bit_mask(4'h9);
                  bit_d    = 4'h9;
                  step_d   = 9'h000;
                  win_d    = 11'h000;
                  age_d    = 12'h000;
               end
            end
         end
         sas_pkg::ST_CONV: begin
            // further shift clocks are ignored until the result is queued
            age_d = age_q + 12'h001;
            if (win_q != sas_pkg::ABORT_LIM) begin
               win_d = win_q + 11'h001;
            end
            if (cs_vfall && win_q != sas_pkg::ABORT_LIM) begin
               state_d = sas_pkg::ST_IDLE;
               trial_d = 10'h000;
            end else if (step_q == sas_pkg::STEP_LAST) begin
               step_d = 9'h000;
               if (bit_q == 4'h0) begin
                  if (ain_over_ref_hi) begin
                     res_d = sas_pkg::RES_ONES;
                  end else if (ain_under_ref_lo) begin
                     res_d = sas_pkg::RES_ZEROS;
                  end else begin
                     res_d = kept;
                  end
                  trial_d = kept;
                  state_d = sas_pkg::ST_DONE;
               end else begin
                  trial_d = kept | bit_mask(bit_q - 4'h1);
                  bit_d   = bit_q - 4'h1;
               end
            end else begin
               step_d = step_q + 9'h001;
            end
         end
         sas_pkg::ST_DONE: begin
            // a full result queue stalls the sequencer here
            if (fifo_in_ready) begin
               state_d = sas_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = sas_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q    <= sas_pkg::ST_IDLE;
         edge_cnt_q <= 4'h0;
         shift_q    <= sas_pkg::RES_RST;
         sample_q   <= 1'b0;
         trial_q    <= 10'h000;
         bit_q      <= 4'h0;
         step_q     <= 9'h000;
         win_q      <= 11'h000;
         res_q      <= sas_pkg::RES_RST;
         age_q      <= 12'h000;
      end else begin
         state_q    <= state_d;
         edge_cnt_q <= edge_cnt_d;
         shift_q    <= shift_d;
         sample_q   <= sample_d;
         trial_q    <= trial_d;
         bit_q      <= bit_d;
         step_q     <= step_d;
         win_q      <= win_d;
         res_q      <= res_d;
         age_q      <= age_d;
      end
   end

   sas_fifo #(
      .WIDTH (sas_pkg::RES_BITS),
      .DEPTH (sas_pkg::FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .reset     (reset),
      .in_valid  (state_q == sas_pkg::ST_DONE),
      .in_ready  (fifo_in_ready),
      .in_data   (res_q),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // output floats as soon as the synchronised select is high
   assign data_oe_n = cs_lvl_q;
   assign data_out  = shift_q[9];
   assign sample_en = sample_q;
   assign dac_code  = trial_q;
   assign conv_busy = (state_q == sas_pkg::ST_CONV) | (state_q == sas_pkg::ST_DONE);

   // checks
   over_code_a: assert property (@(posedge core_clk) disable iff (reset)
      (state_q == sas_pkg::ST_CONV && step_q == sas_pkg::STEP_LAST && bit_q == 4'h0 && !cs_vfall
       && ain_over_ref_hi) |=> res_q == 10'h3ff && state_q == sas_pkg::ST_DONE)
      else $error("over-range input did not give all ones");

   under_code_a: assert property (@(posedge core_clk) disable iff (reset)
      (state_q == sas_pkg::ST_CONV && step_q == sas_pkg::STEP_LAST && bit_q == 4'h0 && !cs_vfall
       && !ain_over_ref_hi && ain_under_ref_lo) |=> res_q == 10'h000)
      else $error("under-range input did not give all zeros");

   clk_ignore_a: assert property (@(posedge core_clk) disable iff (reset)
      (state_q == sas_pkg::ST_XFER && cs_valid_q) |=> $stable(edge_cnt_q) && $stable(shift_q))
      else $error("shift clock acted before select was accepted");

   sample_win_a: assert property (@(posedge core_clk) disable iff (reset)
      sample_en |-> state_q == sas_pkg::ST_XFER && edge_cnt_q >= sas_pkg::SAMPLE_FIRST
      && edge_cnt_q < sas_pkg::SAMPLE_LAST && (!$rose(sample_en) || edge_cnt_q == sas_pkg::SAMPLE_FIRST))
      else $error("sampling window misplaced");

   sample_end_a: assert property (@(posedge core_clk) disable iff (reset)
      $fell(sample_en) && state_q != sas_pkg::ST_IDLE |-> edge_cnt_q == 4'ha && state_q == sas_pkg::ST_CONV)
      else $error("sampling did not end on the tenth falling edge");

   conv_bound_a: assert property (@(posedge core_clk) disable iff (reset)
      state_q == sas_pkg::ST_CONV |-> age_q < sas_pkg::CONV_MAX)
      else $error("conversion ran past its limit");

   abort_a: assert property (@(posedge core_clk) disable iff (reset)
      (state_q == sas_pkg::ST_CONV && cs_vfall && win_q < sas_pkg::ABORT_LIM) |=> state_q == sas_pkg::ST_IDLE)
      else $error("select low in abort window did not abort");

   filt_hold_a: assert property (@(posedge core_clk) disable iff (reset)
      $changed(cs_valid_q) |-> $past(filt_cnt_q) == sas_pkg::FILT_LAST && $past(cs_lvl_q) == cs_valid_q)
      else $error("select accepted before its hold time");

   oe_on_a: assert property (@(posedge core_clk) disable iff (reset)
      $fell(cs_n) |-> ##[1:160] (!data_oe_n || cs_n))
      else $error("output not driven within 1.3 us");

   oe_off_a: assert property (@(posedge core_clk) disable iff (reset)
      $rose(cs_n) |-> ##[1:22] (data_oe_n || !cs_n))
      else $error("output not floated within 180 ns");

   stop_clk_a: assert property (@(posedge core_clk) disable iff (reset)
      $rose(cs_lvl_q) |-> ##[1:181] (cs_valid_q || !cs_lvl_q))
      else $error("shift clock not disabled after select rose");

   shift_bit_a: assert property (@(posedge core_clk) disable iff (reset)
      (state_q == sas_pkg::ST_XFER && io_fall && !cs_valid_q && !cs_lvl_q) |=> data_out == $past(shift_q[8]))
      else $error("result bit not advanced on falling edge");

   conv_done_c: cover property (@(posedge core_clk) disable iff (reset)
      state_q == sas_pkg::ST_CONV ##1 state_q == sas_pkg::ST_DONE);
   abort_c: cover property (@(posedge core_clk) disable iff (reset)
      state_q == sas_pkg::ST_CONV ##1 state_q == sas_pkg::ST_IDLE);
   queue_full_c: cover property (@(posedge core_clk) disable iff (reset)
      state_q == sas_pkg::ST_DONE && !fifo_in_ready);
endmodule
`default_nettype wire

/* File: tb/sas_host_model.sv */
`default_nettype none
module sas_host_model (
   input  wire logic       core_clk,
   output logic            cs_n,
   output logic            io_clk,
   input  wire logic       data_out,
   input  wire logic       data_oe_n,
   input  wire logic       sample_en,
   output logic      [9:0] rx_word,
   output logic      [9:0] samp_word,
   output logic      [7:0] en_lat,
   output logic            rx_stb
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      cs_n = 1'b1;
      io_clk = 1'b0;
      rx_word = 10'h000;
      samp_word = 10'h000;
      en_lat = 8'h00;
      rx_stb = 1'b0;
   end

   // one 80 ns shift clock, low phase first
   task automatic tick(input int i);
      #40 io_clk = 1'b1;
      #38;
      if (i < 10) rx_word[9 - i] = data_out;
      if (i > 0 && i <= 10) samp_word[i - 1] = sample_en;
      #2 io_clk = 1'b0;
   endtask

   task automatic xfer(input int nclk, input bit early);
      int i;
      @(posedge core_clk);
      cs_n <= 1'b0;
      en_lat = 8'h00;
      @(posedge core_clk);
      while (data_oe_n !== 1'b0 && en_lat < 8'hff) begin
         @(posedge core_clk);
         en_lat = en_lat + 8'h01;
      end
      if (early) begin
         for (i = 0; i < 3; i++) tick(99); // early clocks must be ignored
      end
      repeat (200) @(posedge core_clk); // select setup before clocking
      #3;
      // clocks run back to back, so with more than ten clocks a rise follows the tenth fall 40 ns later
      for (i = 0; i < nclk; i++) tick(i);
      #80;
      if (nclk == 10) samp_word[9] = sample_en;
      @(posedge core_clk);
      cs_n <= 1'b1;
      rx_stb <= 1'b1;
      @(posedge core_clk);
      rx_stb <= 1'b0;
   endtask

   // select low again once accepted high, still inside the abort window
   task automatic abort_conv();
      repeat (300) @(posedge core_clk);
      cs_n <= 1'b0;
      repeat (250) @(posedge core_clk);
      cs_n <= 1'b1;
      repeat (200) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin errors++; \
   $display("mismatch at %0t: got %h expected %h", $time, act, exp); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   logic        core_clk;
   logic        reset;
   logic        cs_n;
   logic        io_clk;
   logic        cmp_above;
   logic        over_ref;
   logic        under_ref;
   logic        data_out;
   logic        data_oe_n;
   logic        sample_en;
   logic [9:0]  dac_code;
   logic        conv_busy;
   logic [9:0]  vin;
   logic [9:0]  prev;
   logic [9:0]  host_rx_word;
   logic [9:0]  host_samp;
   logic [7:0]  host_en_lat;
   logic        host_rx_stb;
   logic [9:0]  exp_w;
   logic [15:0] lfsr;
   logic [9:0]  exp_q[$];
   int          errors;
   int          checked;
   int          cyc;
   int          k;

   sas_seq dut (
      .core_clk        (core_clk),
      .reset           (reset),
      .cs_n            (cs_n),
      .io_clk          (io_clk),
      .cmp_above       (cmp_above),
      .ain_over_ref_hi (over_ref),
      .ain_under_ref_lo(under_ref),
      .data_out        (data_out),
      .data_oe_n       (data_oe_n),
      .sample_en       (sample_en),
      .dac_code        (dac_code),
      .conv_busy       (conv_busy)
   );

   sas_host_model host (
      .core_clk (core_clk),
      .cs_n     (cs_n),
      .io_clk   (io_clk),
      .data_out (data_out),
      .data_oe_n(data_oe_n),
      .sample_en(sample_en),
      .rx_word  (host_rx_word),
      .samp_word(host_samp),
      .en_lat   (host_en_lat),
      .rx_stb   (host_rx_stb)
   );

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // comparator: input treated as above the trial code when not below it
   always @(posedge core_clk) begin
      cmp_above <= (vin >= dac_code);
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic run(input int nclk, input bit early, input logic [1:0] rng, input logic [9:0] v, input bit abrt);
      int n;
      exp_q.push_back(prev);
      over_ref <= rng[1];
      under_ref <= rng[0];
      vin <= v;
      host.xfer(nclk, early);
      `CHK(host_en_lat <= sas_pkg::EN_CYC, 1'b1)
      repeat (sas_pkg::DIS_CYC) @(posedge core_clk);
      `CHK(data_oe_n, 1'b1)
      if (abrt) begin
         host.abort_conv();
         `CHK(conv_busy, 1'b0)
         prev = 10'h000;
      end else begin
         n = 0;
         // next transfer only once the conversion is over
         while (conv_busy !== 1'b0 && n < 4000) begin
            @(posedge core_clk);
            n++;
         end
         `CHK(n + sas_pkg::DIS_CYC <= sas_pkg::CONV_CYC, 1'b1)
         prev = rng[1] ? 10'h3ff : (rng[0] ? 10'h000 : v);
         repeat (200) @(posedge core_clk);
      end
      $display("transfer of %0d clocks done", nclk);
   endtask

   // watcher: each received word against the oldest note
   always @(posedge core_clk) begin
      if (host_rx_stb === 1'b1) begin
         exp_w = exp_q.pop_front();
         `CHK(host_rx_word, exp_w)
         `CHK(host_samp, 10'h1fc)
      end
   end

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errors++;
         final_report();
      end
   end

   initial begin
      errors = 0;
      checked = 0;
      cyc = 0;
      lfsr = 16'h0023;
      prev = 10'h000;
      vin = 10'h000;
      over_ref = 1'b0;
      under_ref = 1'b0;
      cmp_above = 1'b0;
      reset = 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      repeat (10) @(posedge core_clk);
      run(10, 1'b0, 2'b10, 10'h155, 1'b0);
      run(16, 1'b1, 2'b01, 10'h2aa, 1'b0);
      run(10, 1'b0, 2'b11, 10'h0f0, 1'b0);
      for (k = 0; k < 4; k++) begin
         lfsr = lfsr_next(lfsr);
         run(10 + int'(lfsr[2:0] % 3'h7), 1'b0, 2'b00, lfsr[9:0], 1'b0);
      end
      lfsr = lfsr_next(lfsr);
      run(10, 1'b0, 2'b00, lfsr[9:0], 1'b1);
      run(11, 1'b0, 2'b00, 10'h201, 1'b0);
      run(10, 1'b0, 2'b00, 10'h000, 1'b0);
      `CHK(exp_q.size(), 0)
      final_report();
   end
endmodule
`undef CHK
`default_nettype wire
